// [hw/iesu_pkg.sv]
// Package for the upper interrupt enable and status block.
// Assumes a 32-bit APB register bus and a single 125 MHz system clock.
package iesu_pkg;

	// Register byte offsets, one aligned word each.
	localparam logic [7:0]  ENA_MID_OFS   = 8'h00;
	localparam logic [7:0]  ENA_HIGH_OFS  = 8'h04;
	localparam logic [7:0]  STAT_MID_OFS  = 8'h08;
	localparam logic [7:0]  STAT_HIGH_OFS = 8'h0C;
	localparam logic [7:0]  EVT_STAT_OFS  = 8'h10;
	localparam logic [7:0]  EVT_MASK_OFS  = 8'h14;
	localparam logic [7:0]  WINNER_OFS    = 8'h18;

	// Reset values of the masks: every source starts enabled at its gate, every event starts masked.
	localparam logic [15:0] ENA_RST       = 16'hFFFF;
	localparam logic [31:0] EVT_MASK_RST  = 32'h0000_0000;

	// Number of the lowest source handled here.
	localparam int          SRC_BASE      = 16;

	// Winner report layout: valid flag then the source number.
	localparam int          WIN_VALID_POS = 8;

	// Both groups of sixteen source lines, high above mid.
	typedef struct packed {
		logic [15:0] high;
		logic [15:0] mid;
	} iesu_src_type;

endpackage

// [hw/iesu_sync.sv]
// Three-stage synchroniser with agreement filter for one group of lines.
// Assumes asynchronous input lines and the system clock domain.
`timescale 1ns/100ps
module iesu_sync #(
	parameter int WIDTH = 16
) (
	input  wire logic             i_sys_clk,
	input  wire logic             i_rst_n,
	input  wire logic [WIDTH-1:0] i_async,
	output logic      [WIDTH-1:0] o_sync
);

	logic [WIDTH-1:0] s1_q;    // First stage, read only by the second.
	logic [WIDTH-1:0] s2_q;    // Second stage.
	logic [WIDTH-1:0] s3_q;    // Third stage.
	logic [WIDTH-1:0] out_q;   // Filtered level.
	logic [WIDTH-1:0] out_d;   // Next filtered level.

	// A change counts only once the second and third stages agree.
	always_comb begin
		out_d = out_q;
		for (int i = 0; i < WIDTH; i++) begin
			if (s2_q[i] == s3_q[i]) begin
				out_d[i] = s3_q[i];
			end
		end
	end

	// Register the chain and the filtered level.
	always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			s1_q  <= '0;
			s2_q  <= '0;
			s3_q  <= '0;
			out_q <= '0;
		end else begin
			s1_q  <= i_async;
			s2_q  <= s1_q;
			s3_q  <= s2_q;
			out_q <= out_d;
		end
	end

	assign o_sync = out_q;

endmodule

// [hw/iesu_top.sv]
// Enable masks, pending status and priority pick for sources 16 to 47.
// Assumes APB from the processor side and raw request lines from peripherals.
//
// Contract
// - Readable writable 16-bit gate mask, sources 32-47.
// - High gate mask resets to all ones.
// - High gate bit n gates source 32+n.
// - Mid gate bit n gates source 16+n.
// - Zero blocks the request, one passes it.
// - Read-only 16-bit status word per group.
// - Status shows raw requests, ignoring gates.
// - High status bits 15..0 are sources 47..32.
// - Mid status bits 15..0 are sources 31..16.
// - Status bit one while its source requests.
// - Highest enabled pending source wins, 47 first.
// - Mid gate mask resets to all ones.
`timescale 1ns/100ps
module iesu_top (
	input  wire logic                  i_sys_clk,
	input  wire logic                  i_rst_n,
	input  wire logic                  i_psel,
	input  wire logic                  i_penable,
	input  wire logic                  i_pwrite,
	input  wire logic [7:0]            i_paddr,
	input  wire logic [31:0]           i_pwdata,
	input  wire logic [3:0]            i_pstrb,
	output logic      [31:0]           o_prdata,
	output logic                       o_pready,
	output logic                       o_pslverr,
	input  wire iesu_pkg::iesu_src_type i_src_req,
	output iesu_pkg::iesu_src_type     o_src_fwd,
	output logic                       o_cpu_req,
	output logic      [5:0]            o_win_num,
	output logic                       o_irq
);

	logic [15:0]                 ena_mid_q;     // Mid group gate mask.
	logic [15:0]                 ena_mid_d;
	logic [15:0]                 ena_high_q;    // High group gate mask.
	logic [15:0]                 ena_high_d;
	logic [31:0]                 evt_stat_q;    // Sticky rising-request events.
	logic [31:0]                 evt_stat_d;
	logic [31:0]                 evt_mask_q;    // Event interrupt mask.
	logic [31:0]                 evt_mask_d;
	logic [31:0]                 prdata_q;      // Registered read data.
	logic [31:0]                 prdata_d;
	logic                        slverr_d;      // Error answer, valid in the access cycle.
	iesu_pkg::iesu_src_type      req_s;         // Synchronised raw requests.
	logic [31:0]                 req_prev_q;    // Last cycle's requests for edges.
	logic [31:0]                 req_rise;      // New requests this cycle.
	logic [31:0]                 gated;         // Requests passing their gates.
	logic [31:0]                 fwd_q;         // Registered forwarded requests.
	logic [5:0]                  win_d;         // Winning source number.
	logic [5:0]                  win_q;
	logic                        win_vld_d;
	logic                        win_vld_q;
	logic                        irq_q;
	logic                        wr_acc;        // Write taken this cycle.
	logic                        rd_acc;        // Read taken this cycle.

	// Both groups cross from peripheral logic through the filtered chain.
	iesu_sync #(.WIDTH(16)) u_sync_mid (
		.i_sys_clk (i_sys_clk),
		.i_rst_n   (i_rst_n),
		.i_async   (i_src_req.mid),
		.o_sync    (req_s.mid)
	);

	iesu_sync #(.WIDTH(16)) u_sync_high (
		.i_sys_clk (i_sys_clk),
		.i_rst_n   (i_rst_n),
		.i_async   (i_src_req.high),
		.o_sync    (req_s.high)
	);

	// Every access completes in its first access cycle, so no wait states.
	assign o_pready = 1'b1;
	assign wr_acc   = i_psel && i_penable && i_pwrite;
	assign rd_acc   = i_psel && i_penable && !i_pwrite;

	// Gate each source by its own bit; gated bit n is source 16+n.
	assign gated    = {req_s.high & ena_high_q, req_s.mid & ena_mid_q};
	assign req_rise = {req_s.high, req_s.mid} & ~req_prev_q;

	// Register writes; writes to the status words fall through untouched.
	always_comb begin
		ena_mid_d  = ena_mid_q;
		ena_high_d = ena_high_q;
		evt_mask_d = evt_mask_q;
		if (wr_acc) begin
			case (i_paddr)
				iesu_pkg::ENA_MID_OFS: begin
					if (i_pstrb[0]) ena_mid_d[7:0] = i_pwdata[7:0];
					if (i_pstrb[1]) ena_mid_d[15:8] = i_pwdata[15:8];
				end
				iesu_pkg::ENA_HIGH_OFS: begin
					if (i_pstrb[0]) ena_high_d[7:0] = i_pwdata[7:0];
					if (i_pstrb[1]) ena_high_d[15:8] = i_pwdata[15:8];
				end
				iesu_pkg::EVT_MASK_OFS: begin
					for (int b = 0; b < 4; b++) begin
						if (i_pstrb[b]) evt_mask_d[b*8 +: 8] = i_pwdata[b*8 +: 8];
					end
				end
				default: begin
					// Status, event and winner words are read-only here.
					ena_mid_d = ena_mid_q;
				end
			endcase
		end
	end

	// Sticky events: a new request in the clearing read cycle survives.
	always_comb begin
		evt_stat_d = evt_stat_q;
		if (rd_acc && i_paddr == iesu_pkg::EVT_STAT_OFS) begin
			evt_stat_d = '0;
		end
		evt_stat_d = evt_stat_d | req_rise;
	end

	// Read mux and error answer for unmapped addresses.
	always_comb begin
		prdata_d = '0;
		slverr_d = 1'b0;
		if (rd_acc || wr_acc) begin
			case (i_paddr)
				iesu_pkg::ENA_MID_OFS:   prdata_d = {16'h0000, ena_mid_q};
				iesu_pkg::ENA_HIGH_OFS:  prdata_d = {16'h0000, ena_high_q};
				iesu_pkg::STAT_MID_OFS:  prdata_d = {16'h0000, req_s.mid};
				iesu_pkg::STAT_HIGH_OFS: prdata_d = {16'h0000, req_s.high};
				iesu_pkg::EVT_STAT_OFS:  prdata_d = evt_stat_q;
				iesu_pkg::EVT_MASK_OFS:  prdata_d = evt_mask_q;
				iesu_pkg::WINNER_OFS: begin
					prdata_d = {23'h000000, win_vld_q, 2'h0, win_q};
				end
				default: begin
					slverr_d = 1'b1;
				end
			endcase
			if (!rd_acc) begin
				prdata_d = '0;
			end
		end
	end

	// Linear priority: scan upward so the highest source is kept last.
	always_comb begin
		win_d     = 6'h00;
		win_vld_d = 1'b0;
		for (int s = 0; s < 32; s++) begin
			if (gated[s]) begin
				win_d     = 6'(s + iesu_pkg::SRC_BASE);
				win_vld_d = 1'b1;
			end
		end
	end

	// Register all state; gate masks reset to all ones, event mask to zero.
	always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			ena_mid_q  <= iesu_pkg::ENA_RST;
			ena_high_q <= iesu_pkg::ENA_RST;
			evt_stat_q <= '0;
			evt_mask_q <= iesu_pkg::EVT_MASK_RST;
			prdata_q   <= '0;
			req_prev_q <= '0;
			fwd_q      <= '0;
			win_q      <= 6'h00;
			win_vld_q  <= 1'b0;
			irq_q      <= 1'b0;
		end else begin
			ena_mid_q  <= ena_mid_d;
			ena_high_q <= ena_high_d;
			evt_stat_q <= evt_stat_d;
			evt_mask_q <= evt_mask_d;
			prdata_q   <= prdata_d;
			req_prev_q <= {req_s.high, req_s.mid};
			fwd_q      <= gated;
			win_q      <= win_d;
			win_vld_q  <= win_vld_d;
			irq_q      <= |(evt_stat_d & evt_mask_d);
		end
	end

	// Read data is combinational from current state so it is valid in the
	// single access cycle; the registered copy is kept for stable idle reads.
	assign o_prdata  = (rd_acc) ? prdata_d : prdata_q;
	assign o_pslverr = slverr_d;
	assign o_src_fwd = fwd_q;
	assign o_cpu_req = win_vld_q;
	assign o_win_num = win_q;
	assign o_irq     = irq_q;

endmodule

// [verif/iesu_chk_sva.sv]
// Checker for the upper interrupt enable and status block.
// Assumes it is bound to iesu_top and sees only its ports.
`timescale 1ns/100ps
module iesu_chk (
	input wire logic                   i_sys_clk,
	input wire logic                   i_rst_n,
	input wire logic                   i_psel,
	input wire logic                   i_penable,
	input wire logic                   i_pwrite,
	input wire logic [7:0]             i_paddr,
	input wire logic [31:0]            o_prdata,
	input wire logic                   o_pslverr,
	input wire iesu_pkg::iesu_src_type i_src_req,
	input wire iesu_pkg::iesu_src_type o_src_fwd,
	input wire logic                   o_cpu_req,
	input wire logic [5:0]             o_win_num
);
	default clocking @(posedge i_sys_clk); endclocking
	default disable iff (!i_rst_n);
	// A read of an access phase, the only time read data is valid.
	wire rd = i_psel && i_penable && !i_pwrite;
	a_fwd_raw: assert property (($stable(i_src_req))[*8] |-> (o_src_fwd & ~i_src_req) == 32'h0)
		else $error("forwarded line without request");
	a_req_any: assert property (o_cpu_req == (o_src_fwd != 32'h0))
		else $error("cpu request disagrees with forwarded lines");
	a_win_bit: assert property (o_cpu_req |-> o_src_fwd[o_win_num - 6'd16])
		else $error("winner is not pending");
	a_win_top: assert property (o_cpu_req |-> (32'(o_src_fwd) >> (o_win_num - 6'd15)) == 32'h0)
		else $error("higher source pending than winner");
	a_stat_mid: assert property (($stable(i_src_req))[*8] ##0 (rd && i_paddr == 8'h08)
		|-> o_prdata == {16'h0, i_src_req.mid})
		else $error("mid status differs from requests");
	a_stat_high: assert property (($stable(i_src_req))[*8] ##0 (rd && i_paddr == 8'h0C)
		|-> o_prdata == {16'h0, i_src_req.high})
		else $error("high status differs from requests");
	a_stat_wr: assert property (i_psel && i_penable && i_pwrite && (i_paddr == 8'h08 || i_paddr == 8'h0C)
		|-> !o_pslverr)
		else $error("status write raised an error");
	a_unmapped: assert property (i_psel && i_penable && i_paddr > 8'h18 |-> o_pslverr)
		else $error("unmapped access gave no error");
endmodule

// [verif/iesu_src_model.sv]
// Model of the peripherals that raise the request lines.
// Assumes each peripheral holds its request as a level on the system clock.
`timescale 1ns/100ps
module iesu_src_model (
	input  wire logic                   i_sys_clk,
	input  wire iesu_pkg::iesu_src_type i_level,
	output iesu_pkg::iesu_src_type      o_req
);
	// Peripherals change their lines from their own flops, never mid-cycle.
	always_ff @(posedge i_sys_clk) begin
		o_req <= i_level;
	end
endmodule

// [verif/tb.sv]
// Self-checking bench for the upper interrupt enable and status block.
// Assumes the package, the design, the checker and the source model.
`timescale 1ns/100ps
module tb;
	logic                   i_sys_clk = 1'b0;
	logic                   i_rst_n = 1'b0;
	logic                   psel = 1'b0, pen = 1'b0, pwr = 1'b0;
	logic [7:0]             paddr = 8'h00;
	logic [31:0]            pwdata = 32'h0, prdata, rdat;
	logic                   pready, pslverr, rerr, cpu_req, irq;
	logic [5:0]             win;
	iesu_pkg::iesu_src_type lvl = 32'h0, req, fwd;
	int                     err_count = 0, num_checks = 0;
	always #4 i_sys_clk = ~i_sys_clk;
	iesu_src_model u_src (.i_sys_clk(i_sys_clk), .i_level(lvl), .o_req(req));
	iesu_top u_dut (.i_sys_clk(i_sys_clk), .i_rst_n(i_rst_n), .i_psel(psel),
		.i_penable(pen), .i_pwrite(pwr), .i_paddr(paddr), .i_pwdata(pwdata),
		.i_pstrb(4'hF), .o_prdata(prdata), .o_pready(pready), .o_pslverr(pslverr),
		.i_src_req(req), .o_src_fwd(fwd), .o_cpu_req(cpu_req), .o_win_num(win), .o_irq(irq));
	task automatic stop_test;
		$display("checks %0d errors %0d", num_checks, err_count);
		if (err_count == 0 && num_checks > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask
	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		num_checks++;
		if (g !== e) begin
			err_count++;
			$display("[ERR] %s exp %h got %h", nm, e, g);
		end
	endtask
	// One APB transfer; the request stands until pready is seen high.
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		n = 0;
		psel <= 1'b1;
		pwr <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge i_sys_clk);
		pen <= 1'b1;
		do begin
			@(posedge i_sys_clk);
			n++;
		end while (pready !== 1'b1 && n < 20);
		rdat = prdata;
		rerr = pslverr;
		psel <= 1'b0;
		pen <= 1'b0;
		if (n == 20) begin
			chk("pready", 32'h1, 32'h0);
			stop_test();
		end
		// Let an edge pass so the next call never re-drives psel in this step.
		@(posedge i_sys_clk);
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] e, input string nm);
		apb(1'b0, a, 32'h0);
		chk(nm, e, rdat);
	endtask
	// Drive new request levels and let them cross the synchroniser.
	task automatic src(input logic [31:0] v);
		lvl <= v;
		repeat (8) @(posedge i_sys_clk);
	endtask
	task automatic t_gates;
		rd(8'h00, 32'h0000FFFF, "mid gate");
		rd(8'h04, 32'h0000FFFF, "high gate");
		apb(1'b1, 8'h04, 32'h0000A5C3);
		rd(8'h04, 32'h0000A5C3, "high gate");
		apb(1'b1, 8'h00, 32'h00003C5A);
		rd(8'h00, 32'h00003C5A, "mid gate");
	endtask
	// Disabled sources still show in status; gates pick what is forwarded.
	task automatic t_status;
		src(32'h8201_4003);
		rd(8'h08, 32'h00004003, "mid status");
		rd(8'h0C, 32'h00008201, "high status");
		chk("fwd", 32'h8001_0002, fwd);
		chk("win", 32'd47, {26'h0, win});
		rd(8'h18, 32'h0000012F, "winner word");
		src(32'h0201_4003);
		chk("win", 32'd32, {26'h0, win});
		apb(1'b1, 8'h0C, 32'h0);
		rd(8'h0C, 32'h00000201, "high status");
		src(32'h0200_4001);
		chk("cpu req", 32'h0, {31'h0, cpu_req});
		rd(8'h08, 32'h00004001, "mid status");
		apb(1'b0, 8'h40, 32'h0);
		chk("unmapped err", 32'h1, {31'h0, rerr});
	endtask
	task automatic t_irq;
		apb(1'b1, 8'h14, 32'hFFFFFFFF);
		src(32'h0200_4003);
		chk("irq set", 32'h1, {31'h0, irq});
		rd(8'h10, 32'h8201_4003, "event status");
		repeat (2) @(posedge i_sys_clk);
		chk("irq clear", 32'h0, {31'h0, irq});
		apb(1'b1, 8'h14, 32'h0);
		src(32'h0200_4007);
		chk("irq masked", 32'h0, {31'h0, irq});
	endtask
	initial begin
		repeat (2) @(posedge i_sys_clk);
		i_rst_n <= 1'b1;
		@(posedge i_sys_clk);
		t_gates();
		t_status();
		t_irq();
		stop_test();
	end
endmodule
bind iesu_top iesu_chk u_chk (.i_sys_clk(i_sys_clk), .i_rst_n(i_rst_n), .i_psel(i_psel),
	.i_penable(i_penable), .i_pwrite(i_pwrite), .i_paddr(i_paddr), .o_prdata(o_prdata),
	.o_pslverr(o_pslverr), .i_src_req(i_src_req), .o_src_fwd(o_src_fwd),
	.o_cpu_req(o_cpu_req), .o_win_num(o_win_num));
